// ===== hw/hpf_pkg.sv
package hpf_pkg;
  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LOOP = 8'h04;
  localparam logic [7:0] A_OFFS = 8'h08;
  localparam logic [7:0] A_RTAMP = 8'h0C;
  localparam logic [7:0] A_OLCFG = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_DIAG = 8'h18;
  localparam logic [7:0] A_SLOT0 = 8'h20;
  localparam logic [7:0] A_SLOT7 = 8'h3C;
  // ==========================================================
  // control register fields
  localparam int B_GO = 0;
  localparam int B_MODE = 1;
  localparam int B_LIB = 3;
  localparam int B_FINE = 4;
  localparam int B_OL = 5;
  localparam int B_LRA = 6;
  localparam int B_SINE = 7;
  localparam int B_ABRK = 8;
  localparam int B_CALT = 9;
  localparam int B_SAMP = 11;
  localparam logic [12:0] CTRL_RST = 13'h0040;
  localparam logic [1:0] MODE_SEQ = 2'h0;
  localparam logic [1:0] MODE_RT = 2'h1;
  localparam logic [1:0] MODE_DIAG = 2'h2;
  localparam logic [1:0] MODE_CAL = 2'h3;
  localparam logic [1:0] CALT_TRIG = 2'h3;
  // loop register: two bits per slot, sequence count above
  localparam int B_MAINREP = 16;
  localparam logic [7:0] OLPER_RST = 8'h00;
  localparam logic [7:0] PEAK_RST = 8'hFF;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [2:0] TICK_COARSE_MS = 3'h5;
  localparam logic [2:0] TICK_FINE_MS = 3'h1;
  localparam logic [3:0] WAIT_UNIT_MS = 4'hA;
  localparam logic [11:0] CAL_MS0 = 12'h096;
  localparam logic [11:0] CAL_MS1 = 12'h0FA;
  localparam logic [11:0] CAL_MS2 = 12'h1F4;
  localparam int SLOTS = 8;
  // ==========================================================
  typedef enum logic [3:0] {
    ST_IDLE, ST_SLOT_RD, ST_SLOT_EVAL, ST_SEG_REQ, ST_SEG_WAIT,
    ST_SEG_RUN, ST_PAUSE, ST_NEXT, ST_RT, ST_DIAG, ST_CAL
  } hpf_state_type;
endpackage

// ===== hw/hpf_slot_mem.sv
`timescale 1ns/1ps
// eight sequence slots, registered read port
module hpf_slot_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [2:0] raddr,
  output logic [7:0] rdata_q
);
  import hpf_pkg::*;
  logic [7:0] mem_q [SLOTS];

  // cleared slots terminate the sequence at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < SLOTS; i++)
        mem_q[i] <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (we)
        mem_q[waddr] <= wdata;
      rdata_q <= mem_q[raddr];
    end
  end
endmodule

// ===== hw/hpf_top.sv
`timescale 1ns/1ps
// Summary of operation
// - mode field picks sequencer, realtime, diagnostics or calibration
// - eight slots hold library effect indices
// - go bit or pin starts slot one
// - advance on nonzero slot, stop otherwise
// - identifiers one to 127 in low bits
// - msb set means pause of low bits times ten ms
// - each slot repeats by its count
// - whole sequence replays, then standby
// - four signed offsets stretch library times
// - extremes map to overdrive and brake
// - ticks five ms, one ms if fine
// - library select bit picks library
// - realtime amplitude streams until stop
// - lra tracks resonance unless open loop
// - open loop scales by peak limit
// - shape only for lra open loop
// - autobrake switches closed loop for brake
// - diagnostics set fault and impedance code
// - lra resyncs direction to existing motion
// - calibration time setting or trigger
// - calibration writes gain, sample raises it
module hpf_top #(
  parameter int unsigned MS_CYCLES = hpf_pkg::MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_interrupt_pin,
  output logic lib_seg_req,
  output logic [6:0] lib_effect_id,
  output logic [4:0] lib_seg_index,
  output logic library_select_bit,
  input wire logic lib_seg_valid,
  input wire logic [7:0] lib_seg_level,
  input wire logic [7:0] lib_seg_ticks,
  input wire logic lib_seg_ramp,
  input wire logic lib_seg_last,
  input wire logic [7:0] lib_eff_max,
  input wire logic [7:0] lib_eff_min,
  output logic drive_active,
  output logic [7:0] drive_level,
  output logic drive_ramp,
  output logic [8:0] drive_ramp_ticks,
  output logic closed_loop,
  output logic shape_sine,
  output logic [6:0] open_loop_period,
  output logic [7:0] overdrive_peak_limit,
  input wire logic motion_valid,
  input wire logic motion_dir,
  output logic drive_dir,
  output logic diag_start,
  input wire logic diag_done,
  input wire logic diag_open_short,
  input wire logic [7:0] diag_z,
  output logic cal_active,
  input wire logic cal_gain_valid,
  input wire logic [1:0] cal_gain,
  output logic [2:0] eff_fb_gain
);
  import hpf_pkg::*;
  // ==========================================================
  // registers and state
  hpf_state_type st_q;
  logic [12:0] ctrl_q;
  logic [18:0] loop_q;
  logic [31:0] offs_q;
  logic [7:0] rtamp_q, cur_scale_q;
  logic [1:0] feedback_amp_gain_q;
  logic diagnostic_fault_flag_q;
  logic [7:0] impedance_code_q;
  logic [2:0] idx_q;
  logic [1:0] slot_rep_q;
  logic [2:0] main_rep_q;
  logic [17:0] pre_q;
  logic [11:0] ms_q, tgt_q;
  logic trig_prev_q;
  logic [7:0] slot_rd;
  logic wr_en, go_wr, pin_rise, trig, busy;
  logic [1:0] mode;
  logic [31:0] rd_word;
  logic mapped;

  assign mode = ctrl_q[B_MODE +: 2];
  assign busy = (st_q != ST_IDLE);
  assign wr_en = psel & penable & pwrite & pready;
  assign go_wr = wr_en & (paddr == A_CTRL) & pwdata[B_GO];
  assign pin_rise = trigger_interrupt_pin & ~trig_prev_q;
  assign trig = go_wr | pin_rise;

  // adjusted tick count, clamped at zero
  function automatic logic [8:0] adj_ticks(input logic [7:0] t,
                                           input logic [7:0] o);
    logic signed [9:0] s;
    s = $signed({2'b00, t}) + $signed({{2{o[7]}}, o});
    adj_ticks = s[9] ? 9'h000 : s[8:0];
  endfunction

  // per slot repeat field
  function automatic logic [1:0] slot_rep(input logic [18:0] l,
                                          input logic [2:0] i);
    slot_rep = l[{i, 1'b0} +: 2];
  endfunction

  // ==========================================================
  // apb slave: one wait-free access, error on unmapped
  always_comb
  begin
    mapped = 1'b1;
    case (paddr)
      A_CTRL: rd_word = {19'h0, ctrl_q};
      A_LOOP: rd_word = {13'h0, loop_q};
      A_OFFS: rd_word = offs_q;
      A_RTAMP: rd_word = {24'h0, rtamp_q};
      A_OLCFG: rd_word = {16'h0, overdrive_peak_limit,
                          1'b0, open_loop_period};
      A_STAT: rd_word = {14'h0, feedback_amp_gain_q, impedance_code_q,
                         3'h0, diagnostic_fault_flag_q, idx_q, busy};
      A_DIAG: rd_word = {22'h0, feedback_amp_gain_q, cur_scale_q};
      default:
      begin
        rd_word = 32'h0;
        mapped = (paddr >= A_SLOT0) && (paddr <= A_SLOT7)
                 && (paddr[1:0] == 2'h0);
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      prdata <= rd_word;
      pslverr <= ~mapped;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // software settings; go bit is not stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      loop_q <= 19'h0;
      offs_q <= 32'h0;
      rtamp_q <= 8'h00;
      open_loop_period <= OLPER_RST[6:0];
      overdrive_peak_limit <= PEAK_RST;
      cur_scale_q <= 8'h00;
    end
    else if (wr_en)
    begin
      case (paddr)
        A_CTRL: ctrl_q <= {pwdata[12:1], 1'b0};
        A_LOOP: loop_q <= pwdata[18:0];
        A_OFFS: offs_q <= pwdata;
        A_RTAMP: rtamp_q <= pwdata[7:0];
        A_OLCFG:
        begin
          open_loop_period <= pwdata[6:0];
          overdrive_peak_limit <= pwdata[15:8];
        end
        A_DIAG: cur_scale_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // slot storage, written straight from the bus
  hpf_slot_mem u_slots (
    .pclk(pclk),
    .presetn(presetn),
    .we(wr_en && (paddr >= A_SLOT0) && (paddr <= A_SLOT7)),
    .waddr(paddr[4:2]),
    .wdata(pwdata[7:0]),
    .raddr(idx_q),
    .rdata_q(slot_rd)
  );

  // ==========================================================
  // millisecond timer shared by segments, pauses and calibration
  logic run_tmr, tmr_done;
  assign run_tmr = (st_q == ST_SEG_RUN) || (st_q == ST_PAUSE)
                   || (st_q == ST_CAL);
  assign tmr_done = (ms_q >= tgt_q);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= 18'h0;
      ms_q <= 12'h0;
    end
    else if (!run_tmr)
    begin
      pre_q <= 18'h0;
      ms_q <= 12'h0;
    end
    else if (pre_q == 18'(MS_CYCLES - 1))
    begin
      pre_q <= 18'h0;
      ms_q <= ms_q + 12'h001;
    end
    else
      pre_q <= pre_q + 18'h00001;
  end

  // segment class from its level against the effect extremes
  logic [7:0] seg_ofs;
  logic [8:0] seg_adj;
  logic [2:0] tick_ms;
  logic is_brake;
  always_comb
  begin
    is_brake = 1'b0;
    if (lib_seg_level == lib_eff_max)
      seg_ofs = offs_q[7:0];
    else if (lib_seg_level == lib_eff_min)
    begin
      seg_ofs = offs_q[31:24];
      is_brake = 1'b1;
    end
    else if (!lib_seg_level[7])
      seg_ofs = offs_q[15:8];
    else
      seg_ofs = offs_q[23:16];
    seg_adj = adj_ticks(lib_seg_ticks, seg_ofs);
    tick_ms = ctrl_q[B_FINE] ? TICK_FINE_MS : TICK_COARSE_MS;
  end

  // calibration length; the trigger option runs until stopped
  logic [11:0] cal_ms;
  always_comb
  begin
    case (ctrl_q[B_CALT +: 2])
      2'h0: cal_ms = CAL_MS0;
      2'h1: cal_ms = CAL_MS1;
      2'h2: cal_ms = CAL_MS2;
      default: cal_ms = 12'hFFF;
    endcase
  end

  // ==========================================================
  // process sequencer
  logic in_brake_q, lib_seg_last_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      idx_q <= 3'h0;
      slot_rep_q <= 2'h0;
      main_rep_q <= 3'h0;
      tgt_q <= 12'h0;
      lib_seg_index <= 5'h0;
      in_brake_q <= 1'b0;
    end
    else if (trig && busy)
      st_q <= ST_IDLE;
    else
      case (st_q)
        ST_IDLE:
          if (trig)
          begin
            idx_q <= 3'h0;
            main_rep_q <= loop_q[B_MAINREP +: 3];
            slot_rep_q <= slot_rep(loop_q, 3'h0);
            tgt_q <= cal_ms;
            case (mode)
              MODE_SEQ: st_q <= ST_SLOT_RD;
              MODE_RT: st_q <= ST_RT;
              MODE_DIAG: st_q <= ST_DIAG;
              default: st_q <= ST_CAL;
            endcase
          end
        ST_SLOT_RD:
          st_q <= ST_SLOT_EVAL; // memory read latency
        ST_SLOT_EVAL:
        begin
          lib_seg_index <= 5'h0;
          tgt_q <= 12'(slot_rd[6:0] * WAIT_UNIT_MS);
          if (slot_rd == 8'h00)
            st_q <= ST_NEXT;
          else if (slot_rd[7])
            st_q <= ST_PAUSE;
          else
            st_q <= ST_SEG_REQ;
        end
        ST_SEG_REQ:
          st_q <= ST_SEG_WAIT;
        ST_SEG_WAIT:
          if (lib_seg_valid)
          begin
            tgt_q <= 12'(seg_adj * tick_ms);
            in_brake_q <= is_brake;
            st_q <= ST_SEG_RUN;
          end
        ST_SEG_RUN:
          if (tmr_done && lib_seg_last_q)
            st_q <= ST_PAUSE; // zero-length pause closes the effect
          else if (tmr_done)
          begin
            lib_seg_index <= lib_seg_index + 5'h01;
            st_q <= ST_SEG_REQ;
          end
        ST_PAUSE:
          if (tmr_done && (st_q == ST_PAUSE))
          begin
            if (slot_rep_q != 2'h0)
            begin
              slot_rep_q <= slot_rep_q - 2'h1;
              st_q <= ST_SLOT_RD;
            end
            else if (idx_q != 3'h7)
            begin
              idx_q <= idx_q + 3'h1;
              slot_rep_q <= slot_rep(loop_q, idx_q + 3'h1);
              st_q <= ST_SLOT_RD;
            end
            else
              st_q <= ST_NEXT;
          end
        ST_NEXT:
          if (main_rep_q != 3'h0 && !(idx_q == 3'h0 && slot_rd == 8'h00))
          begin
            main_rep_q <= main_rep_q - 3'h1;
            idx_q <= 3'h0;
            slot_rep_q <= slot_rep(loop_q, 3'h0);
            st_q <= ST_SLOT_RD;
          end
          else
            st_q <= ST_IDLE;
        ST_RT:
          if (mode != MODE_RT)
            st_q <= ST_IDLE;
        ST_DIAG:
          if (diag_done)
            st_q <= ST_IDLE;
        ST_CAL:
          if (tmr_done && ctrl_q[B_CALT +: 2] != CALT_TRIG)
            st_q <= ST_IDLE;
        default:
          st_q <= ST_IDLE;
      endcase
  end

  // last flag kept with the running segment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lib_seg_last_q <= 1'b0;
    else if (st_q == ST_SEG_WAIT && lib_seg_valid)
      lib_seg_last_q <= lib_seg_last;
    else if (st_q == ST_SLOT_EVAL)
      lib_seg_last_q <= 1'b0;
  end

  // ==========================================================
  // library request and drive outputs
  logic ol, lra, brake_cl;
  logic [15:0] scaled;
  logic [7:0] amp, lib_seg_level_q;
  assign ol = ctrl_q[B_OL];
  assign lra = ctrl_q[B_LRA];
  assign brake_cl = ol & ctrl_q[B_ABRK] & in_brake_q
                    & (st_q == ST_SEG_RUN);
  assign amp = (st_q == ST_RT) ? rtamp_q : lib_seg_level_q;
  assign scaled = amp * overdrive_peak_limit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lib_seg_req <= 1'b0;
      lib_effect_id <= 7'h00;
      library_select_bit <= 1'b0;
      lib_seg_level_q <= 8'h00;
      drive_ramp <= 1'b0;
      drive_ramp_ticks <= 9'h000;
    end
    else
    begin
      lib_seg_req <= (st_q == ST_SEG_REQ);
      library_select_bit <= ctrl_q[B_LIB];
      if (st_q == ST_SLOT_EVAL)
        lib_effect_id <= slot_rd[6:0];
      if (st_q == ST_SEG_WAIT && lib_seg_valid)
      begin
        lib_seg_level_q <= lib_seg_level;
        drive_ramp <= lib_seg_ramp;
        drive_ramp_ticks <= seg_adj;
      end
    end
  end

  // open loop scales codes against the peak limit; rt skips offsets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_active <= 1'b0;
      drive_level <= 8'h00;
      closed_loop <= 1'b1;
      shape_sine <= 1'b0;
    end
    else
    begin
      drive_active <= (st_q == ST_SEG_RUN) || (st_q == ST_RT);
      drive_level <= (ol && !brake_cl) ? scaled[15:8] : amp;
      closed_loop <= ~ol | brake_cl;
      shape_sine <= ctrl_q[B_SINE] & lra & ol & ~brake_cl;
    end
  end

  // lra resync: follow motion at effect start, else default direction
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      drive_dir <= 1'b0;
    else if ((st_q == ST_SLOT_EVAL || (st_q == ST_IDLE && trig)) && lra)
      drive_dir <= motion_valid ? motion_dir : 1'b0;
  end

  // ==========================================================
  // diagnostics, calibration, trigger edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_prev_q <= 1'b0;
      diag_start <= 1'b0;
      cal_active <= 1'b0;
      diagnostic_fault_flag_q <= 1'b0;
      impedance_code_q <= 8'h00;
      feedback_amp_gain_q <= 2'h0;
      eff_fb_gain <= 3'h0;
    end
    else
    begin
      trig_prev_q <= trigger_interrupt_pin;
      diag_start <= (st_q == ST_IDLE) && trig && (mode == MODE_DIAG);
      cal_active <= (st_q == ST_CAL);
      if (st_q == ST_DIAG && diag_done)
      begin
        diagnostic_fault_flag_q <= diag_open_short;
        impedance_code_q <= diag_z;
      end
      if (st_q == ST_CAL && cal_gain_valid)
        feedback_amp_gain_q <= cal_gain;
      else if (wr_en && paddr == A_DIAG)
        feedback_amp_gain_q <= pwdata[9:8];
      eff_fb_gain <= 3'(feedback_amp_gain_q + ctrl_q[B_SAMP +: 2]);
    end
  end

  // ==========================================================
  // checks
  a_seq_start: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_IDLE && trig && mode == MODE_SEQ) |=> st_q == ST_SLOT_RD
    && idx_q == 3'h0) else $error("sequence did not start at slot one");
  a_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
    (busy && trig) |=> st_q == ST_IDLE ##1 !drive_active)
    else $error("stop trigger did not end playback");
  a_zero_stops: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_SLOT_EVAL && slot_rd == 8'h00 && !trig) |=> st_q == ST_NEXT)
    else $error("zero slot did not end the pass");
  a_pause_len: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_SLOT_EVAL && slot_rd[7] && !trig) |=>
    tgt_q == 12'($past(slot_rd[6:0]) * WAIT_UNIT_MS))
    else $error("pause length wrong");
  a_rt_level: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_RT && !ol) |=> drive_level == $past(rtamp_q))
    else $error("realtime amplitude not passed through");
  a_shape_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!lra || !ol) |=> !shape_sine)
    else $error("shape applied outside lra open loop");
  a_fault_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == ST_DIAG && diag_done && diag_open_short && !trig)
    |=> diagnostic_fault_flag_q ##1 st_q == ST_IDLE)
    else $error("diagnostic fault not reported");
  a_loop_mode: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl_q[B_OL]) |=> closed_loop)
    else $error("closed loop dropped without open loop");
endmodule

// ===== verification/hpf_lib_model.sv
`timescale 1ns/1ps
// ==========================================================
// library model: every effect is one overdrive segment of 4 ticks
module hpf_lib_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lib_seg_req,
  output logic lib_seg_valid,
  output logic [7:0] lib_seg_level,
  output logic [7:0] lib_seg_ticks,
  output logic lib_seg_ramp,
  output logic lib_seg_last,
  output logic [7:0] lib_eff_max,
  output logic [7:0] lib_eff_min
);
  logic [1:0] dly_q;
  // answer two cycles late so a design that samples early sees junk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dly_q <= 2'h0;
    else
      dly_q <= {dly_q[0], lib_seg_req};
  end
  // outside valid every data line shows the inverse value
  assign lib_seg_valid = dly_q[1];
  assign lib_seg_level = dly_q[1] ? 8'h40 : 8'hBF;
  assign lib_seg_ticks = dly_q[1] ? 8'h04 : 8'hFB;
  assign lib_seg_ramp = ~dly_q[1];
  assign lib_seg_last = dly_q[1];
  assign lib_eff_max = dly_q[1] ? 8'h40 : 8'hBF;
  assign lib_eff_min = dly_q[1] ? 8'hC0 : 8'h3F;
endmodule

// ===== verification/hpf_top_tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// bench: apb host, trigger pin, diagnostics and motion stimulus
module hpf_top_tb_top;
  import hpf_pkg::*;
  localparam int MSC = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pin = 0, req, lsel, sv, sr, sl, dact;
  logic [6:0] eid, olp;
  logic [7:0] lvl, tk, emax, emin, dlvl, pk;
  logic mv = 0, md = 0, dstart, ddone = 0, dos = 0, ddir, cl;
  logic [7:0] dz = 8'h00;
  logic cgv = 0, cact, ssin, last_err;
  logic [1:0] cg = 2'h0;
  logic [2:0] efg;
  logic [8:0] rtk;
  int num_errors = 0, check_count = 0, cyc = 0;
  logic [6:0] ids[$];
  int tms[$];
  logic [31:0] rd;
  int g0, g1, g2;
  // ==========================================================
  hpf_top #(.MS_CYCLES(MSC)) DUT (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_interrupt_pin(pin),
    .lib_seg_req(req), .lib_effect_id(eid), .lib_seg_index(),
    .library_select_bit(lsel), .lib_seg_valid(sv), .lib_seg_level(lvl),
    .lib_seg_ticks(tk), .lib_seg_ramp(sr), .lib_seg_last(sl),
    .lib_eff_max(emax), .lib_eff_min(emin), .drive_active(dact),
    .drive_level(dlvl), .drive_ramp(), .drive_ramp_ticks(rtk),
    .closed_loop(cl), .shape_sine(ssin), .open_loop_period(olp),
    .overdrive_peak_limit(pk), .motion_valid(mv), .motion_dir(md),
    .drive_dir(ddir), .diag_start(dstart), .diag_done(ddone),
    .diag_open_short(dos), .diag_z(dz), .cal_active(cact),
    .cal_gain_valid(cgv), .cal_gain(cg), .eff_fb_gain(efg));
  hpf_lib_model LIB (.pclk(pclk), .presetn(presetn), .lib_seg_req(req),
    .lib_seg_valid(sv), .lib_seg_level(lvl), .lib_seg_ticks(tk),
    .lib_seg_ramp(sr), .lib_seg_last(sl), .lib_eff_max(emax),
    .lib_eff_min(emin));
  initial
  begin
    forever #2 pclk = ~pclk;
  end
  // log every library request with its cycle number
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (req === 1'b1)
    begin
      ids.push_back(eid);
      tms.push_back(cyc);
    end
  end
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one apb transfer; holds everything until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      num_errors++;
      tally_and_finish();
    end
    r = prdata;
    last_err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1, a, d, r);
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400; n++)
    begin
      apb(0, A_STAT, 32'h0, rd);
      if (rd[0] === 1'b0)
        break;
    end
    if (n == 400)
    begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic pulse_pin();
    @(posedge pclk);
    pin <= 1;
    @(posedge pclk);
    pin <= 0;
  endtask
  // ==========================================================
  task automatic t_reset();
    apb(0, A_CTRL, 32'h0, rd);
    check(rd, {19'h0, CTRL_RST});
    apb(0, A_OFFS, 32'h0, rd);
    check(rd, 32'h0);
    apb(0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    check(last_err, 1);
    check(cl, 1);
    $display("test reset done");
  endtask
  // sequence 3,5,pause,0 played with given control, offsets, main loop
  task automatic run_seq(input logic [31:0] c, input logic [31:0] o,
                         input logic [31:0] lp, input int n, output int g);
    wr(A_OFFS, o);
    wr(A_LOOP, lp);
    ids.delete();
    tms.delete();
    wr(A_CTRL, c);
    wait_idle();
    check(ids.size(), n);
    for (int i = 0; i < n && i < ids.size(); i++)
      check(ids[i], (i % 2) ? 7'h05 : 7'h03);
    check(lsel, c[B_LIB]);
    g = (tms.size() > 1) ? tms[1] - tms[0] : 0;
  endtask
  task automatic t_seq();
    wr(A_SLOT0, 32'h03);
    wr(A_SLOT0 + 8'h04, 32'h05);
    wr(A_SLOT0 + 8'h08, 32'h81);
    wr(A_SLOT0 + 8'h0C, 32'h00);
    mv <= 1;
    md <= 1;
    run_seq(32'h49, 32'h0, 32'h10000, 4, g0);
    check(ddir, 1);
    run_seq(32'h51, 32'h0, 32'h0, 2, g1);
    check(g0 - g1, 4 * 4 * MSC);
    run_seq(32'h41, 32'h02, 32'h0, 2, g2);
    check(g2 - g0, 2 * 5 * MSC);
    check(rtk, 9'h006);
    $display("test sequence done");
  endtask
  task automatic t_stop();
    ids.delete();
    wr(A_CTRL, 32'h41);
    repeat (20) @(posedge pclk);
    pulse_pin();
    repeat (4) @(posedge pclk);
    check(dact, 0);
    wait_idle();
    check(ids.size(), 1);
    $display("test stop done");
  endtask
  task automatic t_rt();
    wr(A_RTAMP, 32'h5C);
    wr(A_OLCFG, 32'h8011);
    wr(A_CTRL, 32'h42);
    pulse_pin();
    repeat (6) @(posedge pclk);
    check({dact, dlvl, cl, ssin}, {10'h2B9, 1'b0});
    wr(A_CTRL, 32'hE2);
    repeat (4) @(posedge pclk);
    check({dlvl, cl, olp, pk}, {8'h2E, 1'b0, 7'h11, 8'h80});
    check(ssin, 1);
    pulse_pin();
    repeat (4) @(posedge pclk);
    check(dact, 0);
    $display("test realtime done");
  endtask
  task automatic t_diag();
    int n;
    // mode is taken from the stored control, so set it before the go
    wr(A_CTRL, 32'h44);
    wr(A_CTRL, 32'h45);
    for (n = 0; n < 50 && dstart !== 1'b1; n++)
      @(posedge pclk);
    check(dstart, 1);
    dz <= 8'h5A;
    dos <= 1;
    ddone <= 1;
    @(posedge pclk);
    ddone <= 0;
    wait_idle();
    check(rd & 32'hFF11, 32'h5A10);
    $display("test diagnostics done");
  endtask
  // 150 ms calibration, gain reported mid-run, sample time adds one
  task automatic t_cal();
    wr(A_CTRL, 32'h846);
    wr(A_CTRL, 32'h847);
    repeat (4) @(posedge pclk);
    check(cact, 1);
    cg <= 2'h2;
    cgv <= 1;
    @(posedge pclk);
    cgv <= 0;
    repeat (500) @(posedge pclk);
    check(cact, 1);
    wait_idle();
    check(cact, 0);
    check(rd[17:16], 2'h2);
    check(efg, 3'h3);
    $display("test calibration done");
  endtask
  // ==========================================================
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_seq();
    t_stop();
    t_rt();
    t_diag();
    t_cal();
    tally_and_finish();
  end
endmodule
